// ### pkg/sadc_pkg.sv
// register map, field layout and reset values of the sensor converter register bank
package sadc_pkg;

  localparam logic [7:0] ADDR_OSC     = 8'h30;
  localparam logic [7:0] ADDR_PAD_OUT = 8'h40;
  localparam logic [7:0] ADDR_PAD_IN  = 8'h41;
  localparam logic [7:0] ADDR_KEY     = 8'h44;
  localparam logic [7:0] ADDR_RES_LO  = 8'h50;
  localparam logic [7:0] ADDR_RES_HI  = 8'h51;
  localparam logic [7:0] ADDR_CFG0    = 8'h52;
  localparam logic [7:0] ADDR_CFG1    = 8'h53;
  localparam logic [7:0] ADDR_CFG2    = 8'h54;
  localparam logic [7:0] ADDR_CFG3    = 8'h55;
  localparam logic [7:0] ADDR_CFG4    = 8'h56;
  localparam logic [7:0] ADDR_CFG5    = 8'h57;

  localparam logic [7:0] RESET_KEY_CODE = 8'hDE;

  // command byte: bit 0 high selects a read
  localparam int CMD_READ_BIT = 0;

  // field positions
  localparam int OSC_ENABLE_BIT       = 0;
  localparam int PAD_ONE_DIR_BIT      = 5;
  localparam int PAD_ZERO_DIR_BIT     = 4;
  localparam int PAD_ONE_DRIVE_BIT    = 1;
  localparam int PAD_ZERO_DRIVE_BIT   = 0;
  localparam int CFG0_START_BIT       = 7;
  localparam int CFG0_CONT_BIT        = 1;
  localparam int CFG0_SHIFT_BIT       = 0;
  localparam int CFG4_READY_BIT       = 7;
  localparam int CFG5_BUSY_BIT        = 7;
  localparam int CFG5_DEF_BIT         = 6;

  // reset values
  localparam logic       OSC_RST      = 1'b1;
  localparam logic [5:0] PAD_CTRL_RST = 6'h30;
  localparam logic [1:0] PAD_RSVD_RD  = 2'h3;
  localparam logic [7:0] KEY_RST      = 8'h00;
  localparam logic [15:0] RESULT_RST  = 16'h0000;
  localparam logic [7:0] CFG0_RST     = 8'h28;
  localparam logic [7:0] CFG1_RST     = 8'hF0;
  localparam logic [7:0] CFG2_RST     = 8'h00;
  localparam logic [7:0] CFG3_RST     = 8'h0C;
  localparam logic [7:0] CFG4_RST     = 8'h00;
  localparam logic [7:0] CFG5_RST     = 8'h00;

  typedef struct packed {
    logic        osc;
    logic [5:0]  pad_ctrl;
    logic [7:0]  key;
    logic [15:0] result;
    logic [7:0]  cfg0;
    logic [7:0]  cfg1;
    logic [7:0]  cfg2;
    logic [7:0]  cfg3;
    logic [7:0]  cfg4;
    logic [7:0]  cfg5;
  } sadc_regs_s;

  localparam sadc_regs_s REGS_RST = '{
    osc: OSC_RST, pad_ctrl: PAD_CTRL_RST, key: KEY_RST, result: RESULT_RST,
    cfg0: CFG0_RST, cfg1: CFG1_RST, cfg2: CFG2_RST, cfg3: CFG3_RST,
    cfg4: CFG4_RST, cfg5: CFG5_RST};

endpackage

// ### logic/sadc_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module sadc_sync import sadc_pkg::*; #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_mclk,
  input  wire logic         i_reset_n,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sadc_sync_s;

  sadc_sync_s s_r;
  sadc_sync_s s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = i_async;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      s_r <= '{meta: RST_VAL, sync: RST_VAL};
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_sync = s_r.sync;

endmodule

// ### logic/sadc_edge.sv
// edge finder on a synchronised level
`timescale 1ns/100ps
module sadc_edge import sadc_pkg::*; #(
  parameter logic RST_LEVEL = 1'b0
) (
  input  wire logic i_mclk,
  input  wire logic i_reset_n,
  input  wire logic i_ce,
  input  wire logic i_level,
  output logic      o_rise,
  output logic      o_fall
);

  typedef struct packed {
    logic prev;
  } sadc_edge_s;

  sadc_edge_s s_r;
  sadc_edge_s s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.prev = i_level;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      s_r <= '{prev: RST_LEVEL};
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_rise = i_ce & i_level & ~s_r.prev;
  assign o_fall = i_ce & ~i_level & s_r.prev;

endmodule

// ### logic/sadc_regbank.sv
// serial-slave register bank of the sensor converter
// Contract
// - registers are reached only over the serial slave, with 8-bit addresses.
// - after power-on reset every field holds its reset value.
// - oscillator bit 0 enables oscillator, resets 1; bits 7:1 read zero.
// - pad output bits 5 and 4 set pad directions, output=1, reset 1.
// - bit 1 drives pad one if output and external reference off.
// - bit 0 drives pad zero if output and reference output off.
// - pad input register is read-only, bits 1:0 show pad levels.
// - writing 0xDE to key register resets the device; register resets 0.
// - 16-bit result readable as low and high read-only bytes, reset zero.
// - writing 1 to config zero bit 7 starts one conversion.
// - config zero bits 6:5 give elementary conversion count exponent, reset 01.
// - config zero bits 4:2 give oversampling exponent minus three, reset 010.
// - config zero bit 1 selects continuous, self-repeating conversions.
// - config zero bit 0 shifts samples out directly without read command.
// - config one holds bias selects (reset 11) and stage enables (reset 0).
// - config two and three hold frequency, gains and offset with reset values.
// - config four bit 7 enables combined ready mode; bits 6:0 offset.
// - config five bit 7 shows activity; writing bit 6 loads defaults, starts.
// - config five bits 5:1 select input, bit 0 selects reference.
// - address auto-increments after each data byte while select stays low.
`timescale 1ns/100ps
module sadc_regbank import sadc_pkg::*; (
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_ce,
  input  wire logic        i_sclk,
  input  wire logic        i_ss_n,
  input  wire logic        i_mosi,
  output logic             o_miso,
  output logic             o_miso_oe,
  input  wire logic        i_pad_zero,
  output logic             o_pad_zero,
  output logic             o_pad_zero_oe,
  input  wire logic        i_pad_one,
  output logic             o_pad_one,
  output logic             o_pad_one_oe,
  input  wire logic        i_ext_reference_on_pad_one,
  input  wire logic        i_reference_out_on_pad_zero,
  input  wire logic        i_conv_done,
  input  wire logic [15:0] i_conv_result,
  output logic             o_conv_start,
  output logic             o_soft_reset,
  output logic             o_osc_enable,
  output logic [7:0]       o_conversion_control,
  output logic [7:0]       o_bias_and_stage_enable,
  output logic [7:0]       o_sampling_and_stage2_setup,
  output logic [7:0]       o_stage1_stage3_gain,
  output logic [7:0]       o_ready_mode_and_stage3_offset,
  output logic [7:0]       o_activity_and_input_select
);

  typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA} sadc_phase_e;

  typedef struct packed {
    sadc_phase_e phase;
    logic [2:0]  bit_cnt;
    logic [7:0]  rx;
    logic [16:0] tx;
    logic [7:0]  addr;
    logic        is_read;
    logic        load_pend;
    logic [7:0]  rd_buf;
    logic        miso_oe;
    logic [1:0]  pad_lvl;
    logic        pad0_out;
    logic        pad0_oe;
    logic        pad1_out;
    logic        pad1_oe;
    logic        conv_start;
    logic        soft_pulse;
    sadc_regs_s  regs;
  } sadc_state_s;

  localparam sadc_state_s STATE_RST = '{
    phase: PH_CMD, bit_cnt: 3'h0, rx: 8'h00, tx: 17'h1FFFF, addr: 8'h00,
    is_read: 1'b0, load_pend: 1'b0, rd_buf: 8'h00, miso_oe: 1'b0,
    pad_lvl: 2'h0, pad0_out: 1'b0, pad0_oe: 1'b0, pad1_out: 1'b0,
    pad1_oe: 1'b0, conv_start: 1'b0, soft_pulse: 1'b0, regs: REGS_RST};

  sadc_state_s s_r;
  sadc_state_s s_nxt;

  logic [4:0] pins_sync;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       ss_rise;
  logic       ss_fall;
  logic       selected;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic       wr_en;
  logic       data_done;

  // pin order: pad one, pad zero, mosi, select, serial clock
  sadc_sync #(
    .W       (5),
    .RST_VAL (5'h02)
  ) u_sync (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .i_async   ({i_pad_one, i_pad_zero, i_mosi, i_ss_n, i_sclk}),
    .o_sync    (pins_sync)
  );

  sadc_edge #(
    .RST_LEVEL (1'b0)
  ) u_sclk_edge (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .i_level   (pins_sync[0]),
    .o_rise    (sclk_rise),
    .o_fall    (sclk_fall)
  );

  sadc_edge #(
    .RST_LEVEL (1'b1)
  ) u_ss_edge (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .i_level   (pins_sync[1]),
    .o_rise    (ss_rise),
    .o_fall    (ss_fall)
  );

  assign selected  = ~pins_sync[1];
  assign byte_done = sclk_rise & selected & (s_r.bit_cnt == 3'h7);
  assign rx_byte   = {s_r.rx[6:0], pins_sync[2]};
  assign wr_en     = byte_done & (s_r.phase == PH_DATA) & ~s_r.is_read;
  assign data_done = byte_done & (s_r.phase == PH_DATA);

  // reserved bits read as fixed values
  function automatic logic [7:0] rd_reg(input logic [7:0] a, input sadc_regs_s r, input logic [1:0] lvl);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADDR_OSC:     v = {7'h00, r.osc};
      ADDR_PAD_OUT: v = {PAD_RSVD_RD, r.pad_ctrl};
      ADDR_PAD_IN:  v = {6'h00, lvl};
      ADDR_KEY:     v = r.key;
      ADDR_RES_LO:  v = r.result[7:0];
      ADDR_RES_HI:  v = r.result[15:8];
      ADDR_CFG0:    v = r.cfg0;
      ADDR_CFG1:    v = r.cfg1;
      ADDR_CFG2:    v = r.cfg2;
      ADDR_CFG3:    v = r.cfg3;
      ADDR_CFG4:    v = r.cfg4;
      ADDR_CFG5:    v = r.cfg5;
      default:      v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    s_nxt            = s_r;
    s_nxt.conv_start = 1'b0;
    s_nxt.soft_pulse = 1'b0;
    s_nxt.miso_oe    = selected;
    s_nxt.pad_lvl    = pins_sync[4:3];

    // framing restarts whenever select is raised or lowered
    if (ss_rise || ss_fall) begin
      s_nxt.phase     = PH_CMD;
      s_nxt.bit_cnt   = 3'h0;
      s_nxt.load_pend = 1'b0;
    end

    // command, address, then data bytes sampled on clock rise
    if (sclk_rise && selected) begin
      s_nxt.rx      = rx_byte;
      s_nxt.bit_cnt = 3'(s_r.bit_cnt + 3'h1);
      if (byte_done) begin
        unique case (s_r.phase)
          PH_CMD: begin
            s_nxt.is_read = rx_byte[CMD_READ_BIT];
            s_nxt.phase   = PH_ADDR;
          end
          PH_ADDR: begin
            s_nxt.addr  = rx_byte;
            s_nxt.phase = PH_DATA;
            if (s_r.is_read) begin
              s_nxt.rd_buf    = rd_reg(rx_byte, s_r.regs, s_r.pad_lvl);
              s_nxt.load_pend = 1'b1;
            end
          end
          PH_DATA: begin
            // next register follows each data byte
            s_nxt.addr = 8'(s_r.addr + 8'h01);
            if (s_r.is_read) begin
              s_nxt.rd_buf    = rd_reg(8'(s_r.addr + 8'h01), s_r.regs, s_r.pad_lvl);
              s_nxt.load_pend = 1'b1;
            end
          end
        endcase
      end
    end

    // bits leave on clock fall, ones fill behind them
    if (sclk_fall && selected) begin
      if (s_r.load_pend) begin
        s_nxt.tx        = {s_r.rd_buf, 9'h1FF};
        s_nxt.load_pend = 1'b0;
      end else begin
        s_nxt.tx = {s_r.tx[15:0], 1'b1};
      end
    end

    // result bytes and activity flag change together
    if (i_conv_done && s_r.regs.cfg5[CFG5_BUSY_BIT]) begin
      s_nxt.regs.result               = i_conv_result;
      s_nxt.regs.cfg5[CFG5_BUSY_BIT]  = 1'b0;
      s_nxt.regs.cfg5[CFG5_DEF_BIT]   = 1'b0;
      s_nxt.regs.cfg0[CFG0_START_BIT] = 1'b0;
      // sample goes straight to the output shifter
      if (s_r.regs.cfg0[CFG0_SHIFT_BIT]) begin
        // ready mode marks the new sample with a low bit first
        if (s_r.regs.cfg4[CFG4_READY_BIT]) begin
          s_nxt.tx = {1'b0, i_conv_result};
        end else begin
          s_nxt.tx = {i_conv_result, 1'b1};
        end
      end
      // continuous mode restarts on its own
      if (s_r.regs.cfg0[CFG0_CONT_BIT]) begin
        s_nxt.conv_start               = 1'b1;
        s_nxt.regs.cfg5[CFG5_BUSY_BIT] = 1'b1;
      end
    end

    // writes come last so a new start wins over a finishing one
    if (wr_en) begin
      unique case (s_r.addr)
        // only the enable bit is stored
        ADDR_OSC:     s_nxt.regs.osc = rx_byte[OSC_ENABLE_BIT];
        ADDR_PAD_OUT: s_nxt.regs.pad_ctrl = rx_byte[5:0];
        ADDR_KEY:     s_nxt.regs.key = rx_byte;
        ADDR_CFG0: begin
          // count, oversampling, mode bits stored whole
          s_nxt.regs.cfg0 = rx_byte;
          if (rx_byte[CFG0_START_BIT]) begin
            s_nxt.conv_start               = 1'b1;
            s_nxt.regs.cfg5[CFG5_BUSY_BIT] = 1'b1;
          end
        end
        ADDR_CFG1:    s_nxt.regs.cfg1 = rx_byte;
        ADDR_CFG2:    s_nxt.regs.cfg2 = rx_byte;
        ADDR_CFG3:    s_nxt.regs.cfg3 = rx_byte;
        ADDR_CFG4:    s_nxt.regs.cfg4 = rx_byte;
        ADDR_CFG5: begin
          // input and reference select; activity bit stays read-only
          s_nxt.regs.cfg5[6:0] = rx_byte[6:0];
          if (rx_byte[CFG5_DEF_BIT]) begin
            s_nxt.regs.cfg0                 = CFG0_RST;
            s_nxt.regs.cfg0[CFG0_START_BIT] = 1'b1;
            s_nxt.regs.cfg1                 = CFG1_RST;
            s_nxt.regs.cfg2                 = CFG2_RST;
            s_nxt.regs.cfg3                 = CFG3_RST;
            s_nxt.regs.cfg4                 = CFG4_RST;
            s_nxt.regs.cfg5[CFG5_BUSY_BIT]  = 1'b1;
            s_nxt.conv_start                = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    if (wr_en && (s_r.addr == ADDR_KEY) && (rx_byte == RESET_KEY_CODE)) begin
      s_nxt.regs       = REGS_RST;
      s_nxt.conv_start = 1'b0;
      s_nxt.soft_pulse = 1'b1;
    end

    // pad one drives only as output with external reference off
    s_nxt.pad1_out = s_nxt.regs.pad_ctrl[PAD_ONE_DRIVE_BIT];
    s_nxt.pad1_oe  = s_nxt.regs.pad_ctrl[PAD_ONE_DIR_BIT] & ~i_ext_reference_on_pad_one;
    // pad zero drives only as output with reference output off
    s_nxt.pad0_out = s_nxt.regs.pad_ctrl[PAD_ZERO_DRIVE_BIT];
    s_nxt.pad0_oe  = s_nxt.regs.pad_ctrl[PAD_ZERO_DIR_BIT] & ~i_reference_out_on_pad_zero;
  end

  // synchronous reset loads every reset value
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      s_r <= STATE_RST;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_miso                         = s_r.tx[16];
  assign o_miso_oe                      = s_r.miso_oe;
  assign o_pad_zero                     = s_r.pad0_out;
  assign o_pad_zero_oe                  = s_r.pad0_oe;
  assign o_pad_one                      = s_r.pad1_out;
  assign o_pad_one_oe                   = s_r.pad1_oe;
  assign o_conv_start                   = s_r.conv_start;
  assign o_soft_reset                   = s_r.soft_pulse;
  assign o_osc_enable                   = s_r.regs.osc;
  assign o_conversion_control           = s_r.regs.cfg0;
  assign o_bias_and_stage_enable        = s_r.regs.cfg1;
  assign o_sampling_and_stage2_setup    = s_r.regs.cfg2;
  assign o_stage1_stage3_gain           = s_r.regs.cfg3;
  assign o_ready_mode_and_stage3_offset = s_r.regs.cfg4;
  assign o_activity_and_input_select    = s_r.regs.cfg5;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  reset_values_a: assert property (
    @(posedge i_mclk) disable iff (1'b0)
    !i_reset_n |=> (s_r.regs.cfg0 == CFG0_RST) && (s_r.regs.cfg3 == CFG3_RST) && o_osc_enable
                   && (s_r.regs.pad_ctrl == PAD_CTRL_RST) && !o_conv_start)
    else $error("register bank not at reset values after reset");

  osc_write_a: assert property (
    (i_ce && wr_en && s_r.addr == ADDR_OSC && !i_conv_done) |=> o_osc_enable == $past(rx_byte[0]))
    else $error("oscillator enable did not follow the write");

  pad_one_oe_a: assert property (
    i_ce && $past(i_ce) && $past(i_reset_n) |-> o_pad_one_oe == ($past(s_nxt.regs.pad_ctrl[PAD_ONE_DIR_BIT])
                                              && !$past(i_ext_reference_on_pad_one)))
    else $error("pad one enable wrong");

  pad_zero_block_a: assert property (
    i_ce && i_reference_out_on_pad_zero ##1 i_ce |-> !o_pad_zero_oe)
    else $error("pad zero driven while reference output on");

  soft_key_a: assert property (
    (i_ce && wr_en && s_r.addr == ADDR_KEY && rx_byte == RESET_KEY_CODE)
    |=> (o_soft_reset && (s_r.regs == REGS_RST)) ##1 (!i_ce || !o_soft_reset))
    else $error("key code did not reset the bank");

  start_write_a: assert property (
    (i_ce && wr_en && s_r.addr == ADDR_CFG0 && rx_byte[CFG0_START_BIT])
    |=> o_conv_start && o_activity_and_input_select[CFG5_BUSY_BIT])
    else $error("start write did not start a conversion");

  continuous_a: assert property (
    (i_ce && i_conv_done && s_r.regs.cfg5[CFG5_BUSY_BIT] && s_r.regs.cfg0[CFG0_CONT_BIT])
    |=> o_conv_start)
    else $error("continuous mode did not restart");

  shift_load_a: assert property (
    (i_ce && i_conv_done && s_r.regs.cfg5[CFG5_BUSY_BIT] && s_r.regs.cfg0[CFG0_SHIFT_BIT]
     && !s_r.regs.cfg4[CFG4_READY_BIT]) |=> o_miso == $past(i_conv_result[15]))
    else $error("sample not presented on output");

  autoinc_a: assert property (
    (i_ce && data_done && !ss_rise) |=> s_r.addr == 8'($past(s_r.addr) + 8'h01))
    else $error("address did not increment");

  result_update_a: assert property (
    (i_ce && i_conv_done && s_r.regs.cfg5[CFG5_BUSY_BIT] && !s_r.regs.cfg0[CFG0_CONT_BIT] && !wr_en)
    |=> (s_r.regs.result == $past(i_conv_result)) && !s_r.regs.cfg5[CFG5_BUSY_BIT])
    else $error("result or activity flag not updated together");

endmodule

// ### testbench/sadc_host_model.sv
// serial host model driving select, clock and data pins of the register bank
`timescale 1ns/100ps
module sadc_host_model (
  input  wire logic i_miso,
  output logic      o_sclk,
  output logic      o_ss_n,
  output logic      o_mosi
);
  initial begin
    o_sclk = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b1;
  end

  task automatic open_f();
    o_ss_n = 1'b0;
    #40;
  endtask

  // released data line shows the inverse of its last bit
  task automatic close_f();
    #40;
    o_ss_n = 1'b1;
    o_mosi = ~o_mosi;
    #160;
  endtask

  // bytes msb first, data set while clock low
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_mosi = tx[i];
      #40;
      o_sclk = 1'b1;
      rx[i] = i_miso;
      #80;
      o_sclk = 1'b0;
      #40;
    end
  endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench of the converter register bank
`timescale 1ns/100ps
module testbench import sadc_pkg::*; ;
  logic        i_mclk, i_reset_n, i_ce, i_sclk, i_ss_n, i_mosi, o_miso, o_miso_oe;
  logic        i_pad_zero, o_pad_zero, o_pad_zero_oe, i_pad_one, o_pad_one, o_pad_one_oe;
  logic        i_ext_ref, i_ref_out, i_conv_done, o_conv_start, o_soft_reset, o_osc_enable;
  logic [15:0] i_conv_result;
  logic [7:0]  o_c0, o_c1, o_c2, o_c3, o_c4, o_c5;
  logic [7:0]  wb [6];
  logic [7:0]  rb [6];
  int          n_fail = 0;
  int          compares = 0;
  int          n_start = 0;
  int          n_soft = 0;

  sadc_regbank dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_sclk(i_sclk),
    .i_ss_n(i_ss_n), .i_mosi(i_mosi), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
    .i_pad_zero(i_pad_zero), .o_pad_zero(o_pad_zero), .o_pad_zero_oe(o_pad_zero_oe),
    .i_pad_one(i_pad_one), .o_pad_one(o_pad_one), .o_pad_one_oe(o_pad_one_oe),
    .i_ext_reference_on_pad_one(i_ext_ref), .i_reference_out_on_pad_zero(i_ref_out),
    .i_conv_done(i_conv_done), .i_conv_result(i_conv_result), .o_conv_start(o_conv_start),
    .o_soft_reset(o_soft_reset), .o_osc_enable(o_osc_enable), .o_conversion_control(o_c0),
    .o_bias_and_stage_enable(o_c1), .o_sampling_and_stage2_setup(o_c2),
    .o_stage1_stage3_gain(o_c3), .o_ready_mode_and_stage3_offset(o_c4),
    .o_activity_and_input_select(o_c5));
  sadc_host_model host (.i_miso(o_miso), .o_sclk(i_sclk), .o_ss_n(i_ss_n), .o_mosi(i_mosi));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    if (o_conv_start === 1'b1) n_start <= n_start + 1;
    if (o_soft_reset === 1'b1) n_soft <= n_soft + 1;
  end

  task automatic final_report();
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic frame(input logic rd, input logic [7:0] a, input int n);
    logic [7:0] x;
    @(negedge i_mclk);
    host.open_f();
    host.xfer({7'h00, rd}, x);
    host.xfer(a, x);
    for (int i = 0; i < n; i++) host.xfer(wb[i], rb[i]);
    host.close_f();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb[0] = d;
    frame(1'b0, a, 1);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    wb[0] = 8'h00;
    frame(1'b1, a, 1);
    chk($sformatf("reg %h", a), e, rb[0]);
  endtask

  task automatic done(input logic [15:0] r);
    @(negedge i_mclk);
    i_conv_done = 1'b1;
    i_conv_result = r;
    @(negedge i_mclk);
    i_conv_done = 1'b0;
    i_conv_result = ~r;
    repeat (2) @(negedge i_mclk);
  endtask

  task automatic t_reset();
    logic [7:0] e [6];
    e = '{CFG0_RST, CFG1_RST, CFG2_RST, CFG3_RST, CFG4_RST, CFG5_RST};
    rchk(ADDR_OSC, {7'h00, OSC_RST});
    rchk(ADDR_PAD_OUT, {PAD_RSVD_RD, PAD_CTRL_RST});
    rchk(ADDR_PAD_IN, 8'h02);
    rchk(ADDR_KEY, KEY_RST);
    rchk(ADDR_RES_LO, RESULT_RST[7:0]);
    rchk(ADDR_RES_HI, RESULT_RST[15:8]);
    frame(1'b1, ADDR_CFG0, 6);
    for (int i = 0; i < 6; i++) chk("cfg rst", e[i], rb[i]);
    chk("cfg0 port", CFG0_RST, o_c0);
  endtask

  task automatic t_rw();
    wb = '{8'h5A, 8'hA5, 8'h3C, 8'h7E, 8'h00, 8'h00};
    frame(1'b0, ADDR_CFG1, 4);
    wb = '{default: 8'h00};
    frame(1'b1, ADDR_CFG1, 4);
    chk("cfg1", 8'h5A, rb[0]);
    chk("cfg2", 8'hA5, rb[1]);
    chk("cfg3", 8'h3C, rb[2]);
    chk("cfg4", 8'h7E, rb[3]);
    chk("cfg1 port", 8'h5A, o_c1);
    chk("cfg4 port", 8'h7E, o_c4);
    chk("cfg2 port", 8'hA5, o_c2);
    chk("cfg3 port", 8'h3C, o_c3);
    wr(ADDR_RES_LO, 8'hFF);
    rchk(ADDR_RES_LO, 8'h00);
    wr(ADDR_OSC, 8'h00);
    chk("osc port", 8'h00, {7'h00, o_osc_enable});
    rchk(ADDR_OSC, 8'h00);
    wr(8'h60, 8'h55);
    rchk(8'h60, 8'h00);
    wr(ADDR_CFG5, 8'h3F);
    rchk(ADDR_CFG5, 8'h3F);
    wr(ADDR_CFG0, 8'h1C);
    rchk(ADDR_CFG0, 8'h1C);
  endtask

  task automatic t_pad();
    wr(ADDR_PAD_OUT, 8'hF3);
    chk("pads", 8'h0F, {4'h0, o_pad_one_oe, o_pad_one, o_pad_zero_oe, o_pad_zero});
    @(negedge i_mclk);
    i_ext_ref = 1'b1;
    i_ref_out = 1'b1;
    repeat (3) @(negedge i_mclk);
    chk("pad oe ref", 8'h00, {6'h00, o_pad_one_oe, o_pad_zero_oe});
    i_ext_ref = 1'b0;
    i_ref_out = 1'b0;
    wr(ADDR_PAD_OUT, 8'hE0);
    chk("pad oe dir", 8'h02, {6'h00, o_pad_one_oe, o_pad_zero_oe});
    i_pad_zero = 1'b1;
    i_pad_one = 1'b0;
    rchk(ADDR_PAD_IN, 8'h01);
  endtask

  task automatic t_conv();
    int s;
    wr(ADDR_CFG5, 8'h00);
    s = n_start;
    wr(ADDR_CFG0, CFG0_RST | 8'h80);
    chk("start", 8'(s + 1), 8'(n_start));
    rchk(ADDR_CFG5, 8'h80);
    chk("busy port", 8'h80, o_c5);
    done(16'hA55A);
    frame(1'b1, ADDR_RES_LO, 2);
    chk("res pair", 8'h5A, rb[0]);
    chk("res pair", 8'hA5, rb[1]);
    rchk(ADDR_CFG5, 8'h00);
    wr(ADDR_CFG1, 8'h00);
    wr(ADDR_CFG5, 8'h40);
    chk("def start", 8'(s + 2), 8'(n_start));
    rchk(ADDR_CFG1, CFG1_RST);
    done(16'h1111);
    wr(ADDR_CFG0, CFG0_RST | 8'h82);
    done(16'h2222);
    chk("cont", 8'(s + 4), 8'(n_start));
    wr(ADDR_CFG0, CFG0_RST);
    done(16'h3333);
    rchk(ADDR_CFG5, 8'h00);
  endtask

  task automatic t_shift();
    logic [7:0] x;
    wr(ADDR_CFG0, CFG0_RST | 8'h81);
    @(negedge i_mclk);
    host.open_f();
    done(16'hC3A5);
    chk("miso oe", 8'h01, {7'h00, o_miso_oe});
    host.xfer(8'h00, x);
    chk("shift hi", 8'hC3, x);
    host.xfer(8'h00, x);
    chk("shift lo", 8'hA5, x);
    host.close_f();
    chk("miso oe idle", 8'h00, {7'h00, o_miso_oe});
    wr(ADDR_CFG0, CFG0_RST);
    rchk(ADDR_RES_LO, 8'hA5);
    // ready mode: low marker bit leads the sample
    wr(ADDR_CFG4, 8'h80);
    wr(ADDR_CFG0, CFG0_RST | 8'h81);
    @(negedge i_mclk);
    host.open_f();
    done(16'h5A3C);
    chk("ready low", 8'h00, {7'h00, o_miso});
    host.xfer(8'h00, x);
    chk("ready hi", 8'h2D, x);
    host.xfer(8'h00, x);
    chk("ready lo", 8'h1E, x);
    host.close_f();
    wr(ADDR_CFG4, 8'h00);
    wr(ADDR_CFG0, CFG0_RST);
    rchk(ADDR_RES_LO, 8'h3C);
  endtask

  task automatic t_key();
    int s;
    s = n_soft;
    wr(ADDR_KEY, 8'h12);
    rchk(ADDR_KEY, 8'h12);
    wr(ADDR_CFG1, 8'h00);
    wr(ADDR_KEY, RESET_KEY_CODE);
    chk("soft pulse", 8'(s + 1), 8'(n_soft));
    rchk(ADDR_KEY, KEY_RST);
    rchk(ADDR_CFG1, CFG1_RST);
    chk("osc after key", 8'h01, {7'h00, o_osc_enable});
  endtask

  initial begin
    #400000;
    n_fail++;
    final_report();
  end

  initial begin
    i_reset_n = 1'b0;
    i_ce = 1'b1;
    i_pad_zero = 1'b0;
    i_pad_one = 1'b1;
    i_ext_ref = 1'b0;
    i_ref_out = 1'b0;
    i_conv_done = 1'b0;
    i_conv_result = 16'h0000;
    repeat (5) @(negedge i_mclk);
    i_reset_n = 1'b1;
    t_reset();
    t_rw();
    t_pad();
    t_conv();
    t_shift();
    t_key();
    final_report();
  end
endmodule
